// ==== rtl/timer_capture_pwm_pkg.sv ====
package timer_capture_pwm_pkg;

   // Register byte offsets on the APB
   localparam logic [7:0] first_mode_offset  = 8'h00;
   localparam logic [7:0] second_mode_offset = 8'h04;
   localparam logic [7:0] first_data_offset  = 8'h08;
   localparam logic [7:0] second_data_offset = 8'h0c;
   localparam logic [7:0] period_low_offset  = 8'h10;
   localparam logic [7:0] duty_low_offset    = 8'h14;
   localparam logic [7:0] high_bits_offset   = 8'h18;
   localparam logic [7:0] edge_select_offset = 8'h1c;
   localparam logic [7:0] port_b_offset      = 8'h20;

   // Reset values
   localparam logic [7:0] mode_reset        = 8'h00;
   localparam logic [7:0] match_value_reset = 8'hff;
   localparam logic [7:0] pwm_reset         = 8'h00;
   localparam logic [3:0] edge_select_reset = 4'h0;
   localparam logic [1:0] port_b_reset      = 2'h0;

   // Edge select codes, one 2-bit field per capture input
   localparam logic [1:0] edge_falling = 2'h0;
   localparam logic [1:0] edge_rising  = 2'h1;

   // Clock select codes
   localparam logic [2:0] first_clock_external = 3'h7;
   localparam logic [1:0] second_clock_div1    = 2'h0;
   localparam logic [1:0] second_clock_div2    = 2'h1;
   localparam logic [1:0] second_clock_div8    = 2'h2;

   // First timer mode register, high bits first
   typedef struct packed {
      logic [2:0] reserved;
      logic       first_capture_select;
      logic       run;
      logic [2:0] first_clock_select;
   } first_mode_type;

   // Second timer mode register
   typedef struct packed {
      logic       duty_polarity;
      logic       wide_mode_enable;
      logic       pwm_enable;
      logic       second_capture_select;
      logic [1:0] second_clock_select;
      logic       run;
      logic       reserved;
   } second_mode_type;

   // Pin function bits
   typedef struct packed {
      logic pwm_pin_function;
      logic compare_pin_function;
   } port_b_function_type;

endpackage

// ==== rtl/timer_capture_pwm_unit.sv ====
// Functional notes
// [RULE1] Each timer enters capture through its own capture-select bit in its mode register.
// [RULE2] In capture mode counting continues; match with data register raises timer interrupt.
// [RULE3] Selected capture edge copies count to capture register, then clears and restarts count.
// [RULE4] Capture edge is falling, rising or both, from the edge select register.
// [RULE5] Every qualifying capture edge also raises that pin's external interrupt.
// [RULE6] Capture, data and count share an address: capture reads capture, writes data.
// [RULE7] 16-bit capture chains both timers; first timer clock internal or external.
// [RULE8] Software sets both second clock-select bits and wide enable for 16-bit modes.
// [RULE9] Compare output toggles pin on each match, giving a 50:50 square wave.
// [RULE10] Software sets compare pin function and clears PWM enable for compare output.
// [RULE11] PWM mode drives the shared pin with up to 10-bit resolution when enabled.
// [RULE12] Period and duty are 10-bit: high-register bits above the 8-bit registers.
// [RULE13] Duty is double-buffered, moving to the active register at period match.
// [RULE14] Duty equal period holds polarity level; duty zero holds the opposite level.
// [RULE15] Duty change shows after current period; period change keeps absolute duty time.
// [RULE16] Software keeps each new period greater than the current duty.
// [RULE17] Software stops the second timer before loading period, duty and high bits.
// [RULE18] Software counts match interrupts between captures for pulses beyond one period.
// [RULE19] Second clock select: oscillator, divided by 2, divided by 8, or first timer clock.
// [RULE20] PWM counter restarts after period; active level while count below active duty.
module timer_capture_pwm_unit (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  capture_edge_input,
   input  wire logic        event_clock_input,
   output logic [1:0]       capture_irq,
   output logic             first_match_irq,
   output logic             second_match_irq,
   output logic             pwm_output_pin,
   output logic             pwm_output_pin_oe
);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and state

   timer_capture_pwm_pkg::first_mode_type      first_timer_mode_reg;
   timer_capture_pwm_pkg::second_mode_type     second_timer_mode_reg;
   timer_capture_pwm_pkg::port_b_function_type port_b_function_reg;
   logic [3:0]  edge_select_reg;
   logic [7:0]  first_match_value_reg;
   logic [7:0]  second_match_value_reg;
   logic [7:0]  first_capture_value_reg;
   logic [7:0]  second_capture_value_reg;
   logic [7:0]  first_count_reg;
   logic [7:0]  second_count_reg;
   logic [7:0]  pwm_period_low;
   logic [7:0]  pwm_duty_low;
   logic [3:0]  pwm_high_bits;
   logic [9:0]  pwm_count;
   logic [9:0]  duty_active;
   logic [10:0] prescale;
   logic        compare_level;
   logic [1:0]  edge_meta;
   logic [1:0]  edge_sync;
   logic [1:0]  edge_last;
   logic        event_meta;
   logic        event_sync;
   logic        event_last;

   ////////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic [10:0] div_mask(input logic [2:0] sel);
      logic [10:0] mask;
      mask = 11'h001;
      case (sel)
         3'h0: mask = 11'h001;
         3'h1: mask = 11'h003;
         3'h2: mask = 11'h007;
         3'h3: mask = 11'h01f;
         3'h4: mask = 11'h07f;
         3'h5: mask = 11'h1ff;
         default: mask = 11'h7ff;
      endcase
      return mask;
   endfunction

   function automatic logic edge_hit(input logic [1:0] mode, input logic now,
                                     input logic last);
      logic hit;
      hit = 1'b0;
      if (mode == timer_capture_pwm_pkg::edge_falling) begin
         hit = last & ~now;
      end else if (mode == timer_capture_pwm_pkg::edge_rising) begin
         hit = now & ~last;
      end else begin
         hit = now ^ last;
      end
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Clock sources

   wire  event_rise = event_sync & ~event_last;
   wire  first_tick = (first_timer_mode_reg.first_clock_select ==
                       timer_capture_pwm_pkg::first_clock_external) ? event_rise :
                      &(prescale | ~div_mask(first_timer_mode_reg.first_clock_select));
   logic second_tick;

   always_comb begin
      case (second_timer_mode_reg.second_clock_select) // see [RULE19]
         timer_capture_pwm_pkg::second_clock_div1: second_tick = 1'b1;
         timer_capture_pwm_pkg::second_clock_div2: second_tick = prescale[0];
         timer_capture_pwm_pkg::second_clock_div8: second_tick = &prescale[2:0];
         default:                                  second_tick = first_tick;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Capture edges

   wire [1:0] edge_qual;
   assign edge_qual[0] = edge_hit(edge_select_reg[1:0], edge_sync[0], edge_last[0]); // see [RULE4]
   assign edge_qual[1] = edge_hit(edge_select_reg[3:2], edge_sync[1], edge_last[1]);

   wire wide_mode  = second_timer_mode_reg.wide_mode_enable;
   wire pwm_mode   = second_timer_mode_reg.pwm_enable & ~wide_mode;
   wire capture0   = edge_qual[0] & first_timer_mode_reg.first_capture_select; // see [RULE1]
   wire capture1   = edge_qual[1] & second_timer_mode_reg.second_capture_select & ~wide_mode;
   wire run0       = first_timer_mode_reg.run & first_tick;
   wire run1       = second_timer_mode_reg.run & second_tick;

   ////////////////////////////////////////////////////////////////////////////////
   // Timer counting, match and capture

   wire [15:0] count16  = {second_count_reg, first_count_reg};
   wire [15:0] match16  = {second_match_value_reg, first_match_value_reg};
   wire        hit16    = run0 & (count16 == match16);
   wire        hit0     = run0 & (first_count_reg == first_match_value_reg);
   wire        hit1     = run1 & ~pwm_mode & (second_count_reg == second_match_value_reg);
   wire        first_ev = wide_mode ? hit16 : hit0;
   wire        second_ev = ~wide_mode & hit1;
   logic [15:0] next_count16;
   logic [7:0]  next_first_count;
   logic [7:0]  next_second_count;

   always_comb begin
      next_count16      = count16;
      next_first_count  = first_count_reg;
      next_second_count = second_count_reg;
      if (wide_mode) begin
         if (capture0) begin
            next_count16 = 16'h0000; // see [RULE7]
         end else if (hit16) begin
            next_count16 = 16'h0000; // see [RULE2]
         end else if (run0) begin
            next_count16 = count16 + 16'h0001;
         end
         next_first_count  = next_count16[7:0];
         next_second_count = next_count16[15:8];
      end else begin
         if (capture0) begin
            next_first_count = 8'h00; // see [RULE3]
         end else if (hit0) begin
            next_first_count = 8'h00; // see [RULE2]
         end else if (run0) begin
            next_first_count = first_count_reg + 8'h01;
         end
         if (capture1 || hit1) begin
            next_second_count = 8'h00; // see [RULE3]
         end else if (run1 && !pwm_mode) begin
            next_second_count = second_count_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         first_count_reg          <= 8'h00;
         second_count_reg         <= 8'h00;
         first_capture_value_reg  <= 8'h00;
         second_capture_value_reg <= 8'h00;
      end else begin
         first_count_reg  <= next_first_count;
         second_count_reg <= next_second_count;
         if (capture0) begin
            first_capture_value_reg <= first_count_reg; // see [RULE3]
            if (wide_mode) begin
               second_capture_value_reg <= second_count_reg; // see [RULE7]
            end
         end
         if (capture1) begin
            second_capture_value_reg <= second_count_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers, prescaler, event pulses

   always_ff @(posedge clock) begin
      if (rst) begin
         edge_meta        <= 2'h0;
         edge_sync        <= 2'h0;
         edge_last        <= 2'h0;
         event_meta       <= 1'b0;
         event_sync       <= 1'b0;
         event_last       <= 1'b0;
         prescale         <= 11'h000;
         capture_irq      <= 2'h0;
         first_match_irq  <= 1'b0;
         second_match_irq <= 1'b0;
      end else begin
         edge_meta        <= capture_edge_input;
         edge_sync        <= edge_meta;
         edge_last        <= edge_sync;
         event_meta       <= event_clock_input;
         event_sync       <= event_meta;
         event_last       <= event_sync;
         prescale         <= prescale + 11'h001;
         capture_irq      <= edge_qual; // see [RULE5]
         first_match_irq  <= first_ev;  // see [RULE2]
         second_match_irq <= second_ev;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Compare output and PWM

   wire [9:0] pwm_period = {pwm_high_bits[3:2], pwm_period_low}; // see [RULE12]
   wire [9:0] duty_hold  = {pwm_high_bits[1:0], pwm_duty_low};
   wire       pwm_wrap   = run1 & ({1'b0, pwm_count} + 11'h001 >= {1'b0, pwm_period});
   wire       pwm_level  = (pwm_count < duty_active) ? // see [RULE20]
                           second_timer_mode_reg.duty_polarity :
                           ~second_timer_mode_reg.duty_polarity; // see [RULE14]
   wire       cmp_hit    = wide_mode ? hit16 : hit1;
   wire       pwm_drive  = pwm_mode & port_b_function_reg.pwm_pin_function;

   always_ff @(posedge clock) begin
      if (rst) begin
         pwm_count         <= 10'h000;
         duty_active       <= 10'h000;
         compare_level     <= 1'b0;
         pwm_output_pin    <= 1'b0;
         pwm_output_pin_oe <= 1'b0;
      end else begin
         if (!pwm_mode) begin
            pwm_count <= 10'h000;
         end else if (pwm_wrap) begin
            pwm_count   <= 10'h000;   // see [RULE20]
            duty_active <= duty_hold; // see [RULE13] [RULE15]
         end else if (run1) begin
            pwm_count <= pwm_count + 10'h001;
         end
         if (cmp_hit) begin
            compare_level <= ~compare_level; // see [RULE9]
         end
         pwm_output_pin    <= pwm_drive ? pwm_level : compare_level; // see [RULE11]
         pwm_output_pin_oe <= pwm_drive | (port_b_function_reg.compare_pin_function &
                                           ~second_timer_mode_reg.pwm_enable);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait-free access phase, read data captured in setup

   wire setup    = psel & ~penable;
   wire write_en = psel & penable & pwrite;
   wire sel_m0   = paddr == timer_capture_pwm_pkg::first_mode_offset;
   wire sel_m1   = paddr == timer_capture_pwm_pkg::second_mode_offset;
   wire sel_d0   = paddr == timer_capture_pwm_pkg::first_data_offset;
   wire sel_d1   = paddr == timer_capture_pwm_pkg::second_data_offset;
   wire sel_pp   = paddr == timer_capture_pwm_pkg::period_low_offset;
   wire sel_pd   = paddr == timer_capture_pwm_pkg::duty_low_offset;
   wire sel_hb   = paddr == timer_capture_pwm_pkg::high_bits_offset;
   wire sel_es   = paddr == timer_capture_pwm_pkg::edge_select_offset;
   wire sel_pb   = paddr == timer_capture_pwm_pkg::port_b_offset;
   wire mapped   = sel_m0 | sel_m1 | sel_d0 | sel_d1 | sel_pp | sel_pd | sel_hb |
                   sel_es | sel_pb;
   wire cap_view0 = first_timer_mode_reg.first_capture_select;
   wire cap_view1 = wide_mode ? first_timer_mode_reg.first_capture_select :
                                second_timer_mode_reg.second_capture_select;
   wire [7:0] data0_view = cap_view0 ? first_capture_value_reg : first_count_reg; // see [RULE6]
   wire [7:0] data1_view = cap_view1 ? second_capture_value_reg : second_count_reg;
   logic [7:0] read_mux;

   assign pready  = psel & penable;
   assign pslverr = psel & penable & ~mapped;

   always_comb begin
      if (sel_m0) begin
         read_mux = first_timer_mode_reg;
      end else if (sel_m1) begin
         read_mux = second_timer_mode_reg;
      end else if (sel_d0) begin
         read_mux = data0_view;
      end else if (sel_d1) begin
         read_mux = data1_view;
      end else if (sel_pp) begin
         read_mux = pwm_period_low;
      end else if (sel_pd) begin
         read_mux = pwm_duty_low;
      end else if (sel_hb) begin
         read_mux = {4'h0, pwm_high_bits};
      end else if (sel_es) begin
         read_mux = {4'h0, edge_select_reg};
      end else if (sel_pb) begin
         read_mux = {6'h00, port_b_function_reg};
      end else begin
         read_mux = 8'h00;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         prdata                 <= 32'h0000_0000;
         first_timer_mode_reg   <= timer_capture_pwm_pkg::mode_reset;
         second_timer_mode_reg  <= timer_capture_pwm_pkg::mode_reset;
         first_match_value_reg  <= timer_capture_pwm_pkg::match_value_reset;
         second_match_value_reg <= timer_capture_pwm_pkg::match_value_reset;
         pwm_period_low         <= timer_capture_pwm_pkg::pwm_reset;
         pwm_duty_low           <= timer_capture_pwm_pkg::pwm_reset;
         pwm_high_bits          <= timer_capture_pwm_pkg::pwm_reset[3:0];
         edge_select_reg        <= timer_capture_pwm_pkg::edge_select_reset;
         port_b_function_reg    <= timer_capture_pwm_pkg::port_b_reset;
      end else begin
         if (setup && !pwrite) begin
            prdata <= {24'h000000, read_mux};
         end
         if (write_en) begin
            if (sel_m0) first_timer_mode_reg <= pwdata[7:0];
            if (sel_m1) second_timer_mode_reg <= pwdata[7:0];
            if (sel_d0) first_match_value_reg <= pwdata[7:0]; // see [RULE6]
            if (sel_d1) second_match_value_reg <= pwdata[7:0];
            if (sel_pp) pwm_period_low <= pwdata[7:0];
            if (sel_pd) pwm_duty_low <= pwdata[7:0]; // see [RULE13]
            if (sel_hb) pwm_high_bits <= pwdata[3:0];
            if (sel_es) edge_select_reg <= pwdata[3:0];
            if (sel_pb) port_b_function_reg <= pwdata[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_capture_clears_count: assert property ( // see [RULE3]
      capture0 && !wide_mode |=> first_count_reg == 8'h00 &&
                                 first_capture_value_reg == $past(first_count_reg))
      else $error("capture did not store and clear the first count");

   a_match_restart_irq: assert property ( // see [RULE2]
      hit0 && !wide_mode && !capture0 |=> first_count_reg == 8'h00 && first_match_irq)
      else $error("match did not restart the count and raise the interrupt");

   a_edge_raises_irq: assert property ( // see [RULE5]
      edge_qual != 2'h0 |=> capture_irq == $past(edge_qual))
      else $error("qualifying edge did not raise the external interrupt");

   a_shared_read_capture: assert property ( // see [RULE6]
      setup && !pwrite && sel_d0 && cap_view0 |=> prdata[7:0] == $past(first_capture_value_reg))
      else $error("capture mode read did not return the capture register");

   a_duty_buffer_load: assert property ( // see [RULE13]
      pwm_mode && pwm_wrap |=> duty_active == $past(duty_hold) && pwm_count == 10'h000)
      else $error("active duty not loaded at period match");

   a_duty_held_midway: assert property ( // see [RULE15]
      pwm_mode && !pwm_wrap |=> $stable(duty_active))
      else $error("active duty changed inside a period");

   a_duty_zero_level: assert property ( // see [RULE14]
      pwm_drive && $stable(duty_active) && duty_active == 10'h000 ##1 pwm_drive
      |-> pwm_output_pin == ~second_timer_mode_reg.duty_polarity)
      else $error("zero duty did not hold the inactive level");

   a_compare_toggles: assert property ( // see [RULE9]
      cmp_hit |=> compare_level != $past(compare_level))
      else $error("compare match did not toggle the output");

   a_wide_chain_count: assert property ( // see [RULE7]
      wide_mode && run0 && !hit16 && !capture0 |=> count16 == $past(count16) + 16'h0001)
      else $error("chained count did not advance by one");

   a_fast_clock_select: assert property ( // see [RULE19]
      second_timer_mode_reg.second_clock_select == timer_capture_pwm_pkg::second_clock_div1 &&
      pwm_mode && second_timer_mode_reg.run && !pwm_wrap
      |=> pwm_count == $past(pwm_count) + 10'h001)
      else $error("undivided second clock missed a tick");

   c_capture_event: cover property (capture0 ##1 first_count_reg == 8'h00);
   c_pwm_wrap: cover property (pwm_drive && pwm_wrap);
   c_wide_capture: cover property (wide_mode && capture0);
   c_compare_toggle: cover property (cmp_hit && pwm_output_pin_oe);

endmodule

// ==== tb/pin_partner.sv ====
module pin_partner (
   input  wire logic  clock,
   input  wire logic  pwm_output_pin,
   input  wire logic  pwm_output_pin_oe,
   output logic [1:0] capture_edge_input,
   output logic       event_clock_input
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      capture_edge_input = 2'h0;
      event_clock_input = 1'b0;
   end

   int high_cnt = 0;

   // Cycles in which the driven pin is high
   always @(posedge clock) begin
      high_cnt <= high_cnt + int'(pwm_output_pin_oe === 1'b1 && pwm_output_pin === 1'b1);
   end

   // Pin change, held long enough for the input synchroniser
   task automatic pin_edge(input int idx, input logic lvl);
      @(posedge clock);
      capture_edge_input[idx] <= lvl;
      repeat (8) @(posedge clock);
   endtask

   task automatic event_pulses(input int n);
      repeat (n) begin
         @(posedge clock);
         event_clock_input <= 1'b1;
         repeat (3) @(posedge clock);
         event_clock_input <= 1'b0;
         repeat (3) @(posedge clock);
      end
   endtask
endmodule

// ==== tb/tb_top.sv ====
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic        wr;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] e;
   } row_type;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic [1:0]  capture_edge_input;
   logic        event_clock_input;
   logic [1:0]  capture_irq;
   logic        first_match_irq;
   logic        second_match_irq;
   logic        pwm_output_pin;
   logic        pwm_output_pin_oe;
   int          miscompares = 0;
   int          total_checks = 0;
   int          cap_cnt = 0;
   int          match_cnt = 0;
   int          match1_cnt = 0;
   row_type     rows[9] = '{
      '{1'b0, timer_capture_pwm_pkg::period_low_offset, 32'h0, 32'h0},
      '{1'b0, timer_capture_pwm_pkg::high_bits_offset, 32'h0, 32'h0},
      '{1'b0, timer_capture_pwm_pkg::edge_select_offset, 32'h0, 32'h0},
      '{1'b0, timer_capture_pwm_pkg::port_b_offset, 32'h0, 32'h0},
      '{1'b0, timer_capture_pwm_pkg::second_mode_offset, 32'h0, 32'h0},
      '{1'b1, timer_capture_pwm_pkg::period_low_offset, 32'ha5, 32'ha5},
      '{1'b1, timer_capture_pwm_pkg::high_bits_offset, 32'hff, 32'h0f},
      '{1'b1, timer_capture_pwm_pkg::edge_select_offset, 32'hff, 32'h0f},
      '{1'b1, timer_capture_pwm_pkg::port_b_offset, 32'hff, 32'h03}};

   always #2 clock = ~clock;

   always @(posedge clock) begin
      cap_cnt <= cap_cnt + int'(capture_irq[0] === 1'b1);
      match_cnt <= match_cnt + int'(first_match_irq === 1'b1);
      match1_cnt <= match1_cnt + int'(second_match_irq === 1'b1);
   end

   timer_capture_pwm_unit timer_capture_pwm_unit_inst (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .capture_edge_input(capture_edge_input), .event_clock_input(event_clock_input),
      .capture_irq(capture_irq), .first_match_irq(first_match_irq),
      .second_match_irq(second_match_irq), .pwm_output_pin(pwm_output_pin),
      .pwm_output_pin_oe(pwm_output_pin_oe));

   pin_partner pin_partner_inst (
      .clock(clock), .pwm_output_pin(pwm_output_pin), .pwm_output_pin_oe(pwm_output_pin_oe),
      .capture_edge_input(capture_edge_input), .event_clock_input(event_clock_input));

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Stop, load, then start the second timer in PWM mode
   task automatic pwm(input logic [7:0] mode, input logic [3:0] hi, input logic [7:0] per,
                      input logic [7:0] duty, input int exp);
      int base;
      apb(1'b1, timer_capture_pwm_pkg::second_mode_offset, 32'h0);
      apb(1'b1, timer_capture_pwm_pkg::period_low_offset, {24'h0, per});
      apb(1'b1, timer_capture_pwm_pkg::duty_low_offset, {24'h0, duty});
      apb(1'b1, timer_capture_pwm_pkg::high_bits_offset, {28'h0, hi});
      apb(1'b1, timer_capture_pwm_pkg::port_b_offset, 32'h2);
      apb(1'b1, timer_capture_pwm_pkg::second_mode_offset, {24'h0, mode});
      repeat (600) @(posedge clock);
      base = pin_partner_inst.high_cnt;
      repeat (520) @(posedge clock);
      `CHK("pwm_oe", 1'b1, pwm_output_pin_oe)
      `CHK("pwm_high", exp, pin_partner_inst.high_cnt - base)
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      complete_run;
   end

   initial begin
      int base;
      int base1;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         `CHK("reg", rows[i].e, rd)
      end
      apb(1'b0, 8'h24, 32'h0);
      `CHK("unmapped", 1'b1, err)
      // Capture on event clock, rising edge on pin 0
      apb(1'b1, timer_capture_pwm_pkg::edge_select_offset, 32'h1);
      apb(1'b1, timer_capture_pwm_pkg::first_mode_offset, 32'h1f);
      pin_partner_inst.event_pulses(5);
      pin_partner_inst.pin_edge(0, 1'b1);
      apb(1'b0, timer_capture_pwm_pkg::first_data_offset, 32'h0);
      `CHK("capture", 32'h5, rd)
      apb(1'b1, timer_capture_pwm_pkg::first_data_offset, 32'h77);
      apb(1'b0, timer_capture_pwm_pkg::first_data_offset, 32'h0);
      `CHK("capture_kept", 32'h5, rd)
      pin_partner_inst.event_pulses(3);
      pin_partner_inst.pin_edge(0, 1'b0);
      pin_partner_inst.pin_edge(0, 1'b1);
      apb(1'b0, timer_capture_pwm_pkg::first_data_offset, 32'h0);
      `CHK("restart", 32'h3, rd)
      pin_partner_inst.pin_edge(0, 1'b0);
      for (int code = 0; code < 3; code++) begin
         apb(1'b1, timer_capture_pwm_pkg::edge_select_offset, code);
         base = cap_cnt;
         pin_partner_inst.pin_edge(0, 1'b1);
         pin_partner_inst.pin_edge(0, 1'b0);
         `CHK("edges", (code == 2) ? 2 : 1, cap_cnt - base)
      end
      apb(1'b1, timer_capture_pwm_pkg::first_data_offset, 32'h2);
      base = match_cnt;
      pin_partner_inst.event_pulses(6);
      `CHK("match", 2, match_cnt - base)
      // Chained 16-bit capture of 260 events
      apb(1'b1, timer_capture_pwm_pkg::edge_select_offset, 32'h1);
      apb(1'b1, timer_capture_pwm_pkg::second_mode_offset, 32'h4c);
      pin_partner_inst.pin_edge(0, 1'b1);
      pin_partner_inst.pin_edge(0, 1'b0);
      pin_partner_inst.event_pulses(260);
      pin_partner_inst.pin_edge(0, 1'b1);
      apb(1'b0, timer_capture_pwm_pkg::first_data_offset, 32'h0);
      `CHK("wide_low", 32'h04, rd)
      apb(1'b0, timer_capture_pwm_pkg::second_data_offset, 32'h0);
      `CHK("wide_high", 32'h01, rd)
      pin_partner_inst.pin_edge(0, 1'b0);
      pwm(8'ha2, 4'h0, 8'd10, 8'd3, 156);
      pwm(8'h22, 4'h0, 8'd10, 8'd3, 364);
      pwm(8'ha2, 4'h0, 8'd10, 8'd10, 520);
      pwm(8'ha2, 4'h0, 8'd10, 8'd0, 0);
      pwm(8'h22, 4'h0, 8'd10, 8'd0, 520);
      pwm(8'ha2, 4'h4, 8'd4, 8'd130, 260);
      // Compare output: match every 5 ticks, pin period 10
      apb(1'b1, timer_capture_pwm_pkg::second_mode_offset, 32'h0);
      apb(1'b1, timer_capture_pwm_pkg::second_data_offset, 32'h4);
      apb(1'b1, timer_capture_pwm_pkg::port_b_offset, 32'h1);
      apb(1'b1, timer_capture_pwm_pkg::second_mode_offset, 32'h2);
      repeat (100) @(posedge clock);
      base = pin_partner_inst.high_cnt;
      base1 = match1_cnt;
      repeat (520) @(posedge clock);
      `CHK("compare_high", 260, pin_partner_inst.high_cnt - base)
      `CHK("second_match", 104, match1_cnt - base1)
      // Reset in mid-run
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      `CHK("reset_oe", 1'b0, pwm_output_pin_oe)
      apb(1'b0, timer_capture_pwm_pkg::second_mode_offset, 32'h0);
      `CHK("reset_mode", 32'h0, rd)
      complete_run;
   end
endmodule
